// ---- logic/cell_monitor_pkg.sv ----
// constants, register map and state encoding for the cell monitor conversion control
package cell_monitor_pkg;

  // clock and acquisition timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BASE_ACQ_NS = 1000;
  localparam int ACQ_CYC_BASE = (BASE_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_CNT_W = 11;

  // channel and data sizes
  localparam int NUM_CELLS = 6;
  localparam int NUM_AUX = 6;
  localparam int NUM_CH = 12;
  localparam int RES_W = 12;
  localparam int ACC_W = 15;
  localparam int FRAME_W = 24;
  localparam int REPLY_W = 23;
  localparam int BIT_CNT_W = 5;

  // register addresses carried in a frame
  localparam logic [3:0] REG_CELL0 = 4'h0;
  localparam logic [3:0] REG_AUX0 = 4'h6;
  localparam logic [3:0] REG_CTRL = 4'hC;
  localparam logic [3:0] REG_UPPER = 4'hD;
  localparam logic [3:0] REG_LOWER = 4'hE;
  localparam logic [3:0] REG_BAL = 4'hF;

  // control register fields
  localparam int CTRL_W = 6;
  localparam int CTRL_ACQ_LSB = 0;
  localparam int CTRL_AVG_LSB = 2;
  localparam int CTRL_CS_START_BIT = 4;
  localparam int CTRL_ALERT_EN_BIT = 5;

  // reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [11:0] UPPER_RST = 12'hFFF;
  localparam logic [11:0] LOWER_RST = 12'h000;
  localparam logic [5:0] BAL_RST = 6'h00;
  // sync vector order: addr[2:0], alert_in, conversion_start_pin_n, sdi, sclk, cs_n
  localparam logic [7:0] PIN_SYNC_RST = 8'h09;

  // frame fields: write flag, device address, register, data
  localparam int FR_WR_BIT = 23;
  localparam int FR_DEV_LSB = 20;
  localparam int FR_REG_LSB = 16;

  // conversion sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACQ = 3'b001,
    ST_CONV = 3'b010,
    ST_STORE = 3'b011
  } conv_state_t;

endpackage

// ---- logic/result_averager.sv ----
// accumulator that averages one, two, four or eight conversions of a channel
`timescale 1ns/1ps
module result_averager (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic add,
  input wire logic [1:0] avg_sel,
  // sample in, mean out
  input wire logic [cell_monitor_pkg::RES_W-1:0] sample,
  output logic [cell_monitor_pkg::RES_W-1:0] mean
);
  import cell_monitor_pkg::*;

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic [ACC_W-1:0] shifted;

  // running sum, cleared between channels
  assign acc_nxt = clear ? '0 : (add ? acc_r + {{(ACC_W-RES_W){1'b0}}, sample} : acc_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // divide by the sample count, dropping the fraction
  assign shifted = acc_r >> avg_sel; // [R13]
  assign mean = shifted[RES_W-1:0]; // [R13]

endmodule

// ---- logic/cell_monitor_conversion_control.sv ----
// conversion sequencer, register file, serial link and chain relay of the cell monitor
`timescale 1ns/1ps
// How it works
// (R1) one start pulse on the start pin converts all twelve channels
// (R2) a rising chip select also starts the sequence when enabled
// (R3) every channel result goes into its own result register
// (R4) each channel gets at least one microsecond of acquisition and conversion
// (R5) a control field lengthens the acquisition time per channel
// (R6) averaging takes two, four or eight conversions per channel
// (R7) after reset: one microsecond per channel and averaging field zero
// (R8) results and registers are reached only through the four-wire serial link
// (R9) alert rises when a result leaves the upper or lower threshold
// (R10) six cell-balance outputs are switched on or off by a register
// (R11) data from the device above is passed down on the serial output
// (R12) host control lines and data are relayed up to the device above
// (R13) averaged result is the truncated arithmetic mean
module cell_monitor_conversion_control (
  // system clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // host serial link, clocked by the host
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  // chain toward the device above
  output logic chain_sclk_up,
  output logic chain_cs_n_up,
  output logic chain_sdo_up,
  output logic chain_conversion_start_pin_n_up,
  input wire logic chain_sdi_down,
  input wire logic chain_alert_in,
  // conversion start pin and address strap
  input wire logic conversion_start_pin_n,
  input wire logic [2:0] device_addr,
  // converter core
  output logic adc_start,
  output logic [3:0] adc_channel,
  input wire logic adc_done,
  input wire logic [cell_monitor_pkg::RES_W-1:0] adc_data,
  // status and balance drive
  output logic alert_out,
  output logic busy,
  output logic [cell_monitor_pkg::NUM_CELLS-1:0] cell_balance_output
);
  import cell_monitor_pkg::*;

  // result slot for a sequence position: cells run 6 down to 1, aux run 1 up to 6
  function automatic logic [3:0] slot_of(input logic [3:0] pos);
    if (pos < 4'(NUM_CELLS)) begin
      slot_of = REG_CELL0 + 4'(NUM_CELLS - 1) - pos;
    end else begin
      slot_of = pos;
    end
  endfunction

  // ---------------- link clock domain ----------------
  logic link_rst_n;
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  logic [FRAME_W-2:0] shift_r;
  logic [REPLY_W-1:0] out_sh_r;
  logic own_r;
  logic chain_bit_r;
  logic [FRAME_W-1:0] hold_r;
  logic tgl_r;
  logic sdo_r;
  logic frame_last;

  // ---------------- reference clock domain ----------------
  logic [7:0] pin_meta_r;
  logic [7:0] pin_sync_r;
  logic tgl_meta_r;
  logic tgl_sync_r;
  logic tgl_seen_r;
  logic cs_prev_r;
  logic conversion_start_pin_prev_r;
  logic [2:0] dev_id_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [RES_W-1:0] upper_r;
  logic [RES_W-1:0] lower_r;
  logic [NUM_CELLS-1:0] bal_r;
  logic [RES_W-1:0] res_r [NUM_CH];
  logic [REPLY_W-1:0] rd_word_r;
  logic own_rd_r;
  conv_state_t state_r;
  conv_state_t state_nxt;
  logic [3:0] ch_idx_r;
  logic [2:0] samp_cnt_r;
  logic [ACQ_CNT_W-1:0] cnt_r;
  logic adc_start_r;
  logic busy_r;
  logic alert_own_r;
  logic alert_out_r;
  logic sclk_up_r;
  logic cs_up_r;
  logic sdo_up_r;
  logic conversion_start_pin_up_r;

  // the link logic is held cleared whenever the frame is closed
  assign link_rst_n = rst_n & ~spi_cs_n;
  assign frame_last = (bit_cnt_r == BIT_CNT_W'(FRAME_W - 1));

  // shift in command bits, shift out the reply prepared by the reference domain
  always_ff @(posedge spi_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_r <= '0;
      shift_r <= '0;
      out_sh_r <= '0;
      own_r <= 1'b0;
      chain_bit_r <= 1'b0;
    end else begin
      // counter parks one past the last bit so extra clocks never re-capture a word
      bit_cnt_r <= (bit_cnt_r == BIT_CNT_W'(FRAME_W)) ? bit_cnt_r : bit_cnt_r + 1'b1;
      shift_r <= {shift_r[FRAME_W-3:0], spi_sdi}; // [R8]
      chain_bit_r <= chain_sdi_down; // [R11]
      if (bit_cnt_r == '0) begin
        out_sh_r <= rd_word_r; // [R8]
        own_r <= own_rd_r;
      end else begin
        out_sh_r <= {out_sh_r[REPLY_W-2:0], 1'b0};
      end
    end
  end

  // a complete frame is parked and announced by a toggle; it must outlive the frame
  always_ff @(posedge spi_sclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= '0;
      tgl_r <= 1'b0;
    end else if (frame_last) begin
      hold_r <= {shift_r, spi_sdi}; // [R8]
      tgl_r <= ~tgl_r;
    end
  end

  // output changes on the falling edge: own reply or data from the device above
  always_ff @(negedge spi_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sdo_r <= 1'b0;
    end else begin
      sdo_r <= own_r ? out_sh_r[REPLY_W-1] : chain_bit_r; // [R11]
    end
  end
  assign spi_sdo = sdo_r;

  // ---------------- pin synchronisers ----------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= PIN_SYNC_RST;
      pin_sync_r <= PIN_SYNC_RST;
      tgl_meta_r <= 1'b0;
      tgl_sync_r <= 1'b0;
      tgl_seen_r <= 1'b0;
    end else begin
      pin_meta_r <= {device_addr, chain_alert_in, conversion_start_pin_n, spi_sdi, spi_sclk, spi_cs_n};
      pin_sync_r <= pin_meta_r;
      tgl_meta_r <= tgl_r;
      tgl_sync_r <= tgl_meta_r;
      tgl_seen_r <= tgl_sync_r;
    end
  end

  // named views of the synchronised pins
  logic cs_s;
  logic sclk_s;
  logic sdi_s;
  logic conversion_start_pin_s;
  logic alert_in_s;
  assign cs_s = pin_sync_r[0];
  assign sclk_s = pin_sync_r[1];
  assign sdi_s = pin_sync_r[2];
  assign conversion_start_pin_s = pin_sync_r[3];
  assign alert_in_s = pin_sync_r[4];

  // relay of host lines upward, all with the same latency to keep their timing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_up_r <= 1'b0;
      cs_up_r <= 1'b1;
      sdo_up_r <= 1'b0;
      conversion_start_pin_up_r <= 1'b1;
    end else begin
      sclk_up_r <= sclk_s; // [R12]
      cs_up_r <= cs_s; // [R12]
      sdo_up_r <= sdi_s; // [R12]
      conversion_start_pin_up_r <= conversion_start_pin_s; // [R12]
    end
  end
  assign chain_sclk_up = sclk_up_r;
  assign chain_cs_n_up = cs_up_r;
  assign chain_sdo_up = sdo_up_r;
  assign chain_conversion_start_pin_n_up = conversion_start_pin_up_r;

  // ---------------- frame decode ----------------
  logic new_word;
  logic fr_wr;
  logic [2:0] fr_dev;
  logic [3:0] fr_reg;
  logic [15:0] fr_data;
  logic fr_mine;
  logic wr_hit;
  logic rd_cmd;
  assign new_word = tgl_sync_r ^ tgl_seen_r;
  assign fr_wr = hold_r[FR_WR_BIT];
  assign fr_dev = hold_r[FR_DEV_LSB +: 3];
  assign fr_reg = hold_r[FR_REG_LSB +: 4];
  assign fr_data = hold_r[15:0];
  assign fr_mine = (fr_dev == dev_id_r);
  assign wr_hit = new_word & fr_wr & fr_mine; // [R8]
  assign rd_cmd = new_word & ~fr_wr;

  // control field views
  logic [1:0] acq_sel;
  logic [1:0] avg_sel;
  logic cs_start_en;
  logic alert_en;
  assign acq_sel = ctrl_r[CTRL_ACQ_LSB +: 2]; // [R5]
  assign avg_sel = ctrl_r[CTRL_AVG_LSB +: 2]; // [R6]
  assign cs_start_en = ctrl_r[CTRL_CS_START_BIT];
  assign alert_en = ctrl_r[CTRL_ALERT_EN_BIT];

  // writable registers; the strap is sampled continuously after release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_id_r <= 3'h0;
      ctrl_r <= CTRL_RST; // [R7]
      upper_r <= UPPER_RST;
      lower_r <= LOWER_RST;
      bal_r <= BAL_RST;
    end else begin
      dev_id_r <= pin_sync_r[7:5];
      if (wr_hit && fr_reg == REG_CTRL) begin
        ctrl_r <= fr_data[CTRL_W-1:0]; // [R5] [R6]
      end
      if (wr_hit && fr_reg == REG_UPPER) begin
        upper_r <= fr_data[RES_W-1:0]; // [R9]
      end
      if (wr_hit && fr_reg == REG_LOWER) begin
        lower_r <= fr_data[RES_W-1:0]; // [R9]
      end
      if (wr_hit && fr_reg == REG_BAL) begin
        bal_r <= fr_data[NUM_CELLS-1:0]; // [R10]
      end
    end
  end
  assign cell_balance_output = bal_r;

  // read data selection
  logic [15:0] rd_data;
  assign rd_data = (fr_reg < REG_CTRL) ? {4'h0, res_r[fr_reg]} :
                   (fr_reg == REG_CTRL) ? {4'h0, busy_r, alert_own_r, 4'h0, ctrl_r} :
                   (fr_reg == REG_UPPER) ? {4'h0, upper_r} :
                   (fr_reg == REG_LOWER) ? {4'h0, lower_r} :
                   {10'h000, bal_r};

  // reply for the next frame; a read for another device hands the output to the chain
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_word_r <= '0;
      own_rd_r <= 1'b0;
    end else if (rd_cmd) begin
      rd_word_r <= {dev_id_r, fr_reg, rd_data}; // [R8]
      own_rd_r <= fr_mine; // [R11]
    end
  end

  // ---------------- conversion sequencer ----------------
  logic conversion_start_pin_fall;
  logic cs_rise;
  logic start_req;
  logic acq_done;
  logic last_samp;
  logic last_ch;
  logic [ACQ_CNT_W-1:0] acq_load;
  logic [RES_W-1:0] mean;
  logic [3:0] slot;
  logic out_of_range;
  assign conversion_start_pin_fall = conversion_start_pin_prev_r & ~conversion_start_pin_s; // [R1]
  assign cs_rise = ~cs_prev_r & cs_s & cs_start_en; // [R2]
  assign start_req = conversion_start_pin_fall | cs_rise;
  assign acq_load = ACQ_CNT_W'((ACQ_CYC_BASE << acq_sel) - 1); // [R4] [R5]
  assign acq_done = (cnt_r == '0);
  assign last_samp = (samp_cnt_r == 3'((1 << avg_sel) - 1)); // [R6]
  assign last_ch = (ch_idx_r == 4'(NUM_CH - 1)); // [R1]
  assign slot = slot_of(ch_idx_r); // [R3]
  assign out_of_range = (mean > upper_r) | (mean < lower_r); // [R9]

  // edge detectors on the synchronised start lines
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev_r <= 1'b1;
      conversion_start_pin_prev_r <= 1'b1;
    end else begin
      cs_prev_r <= cs_s;
      conversion_start_pin_prev_r <= conversion_start_pin_s;
    end
  end

  // next state; starts during a running sequence are ignored
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_req) begin
          state_nxt = ST_ACQ; // [R1] [R2]
        end
      end
      ST_ACQ: begin
        if (acq_done) begin
          state_nxt = ST_CONV; // [R4]
        end
      end
      ST_CONV: begin
        if (adc_done) begin
          state_nxt = last_samp ? ST_STORE : ST_ACQ; // [R6]
        end
      end
      ST_STORE: begin
        state_nxt = last_ch ? ST_IDLE : ST_ACQ; // [R1]
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // sequencer registers: channel, sample count, acquisition timer, core strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      ch_idx_r <= 4'h0;
      samp_cnt_r <= 3'h0;
      cnt_r <= '0;
      adc_start_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      adc_start_r <= (state_r == ST_ACQ) && acq_done; // [R4]
      busy_r <= (state_nxt != ST_IDLE);
      if (state_r == ST_IDLE && start_req) begin
        ch_idx_r <= 4'h0;
        samp_cnt_r <= 3'h0;
        cnt_r <= acq_load; // [R4]
      end else if (state_r == ST_ACQ && !acq_done) begin
        cnt_r <= cnt_r - 1'b1;
      end else if (state_r == ST_CONV && adc_done) begin
        samp_cnt_r <= last_samp ? 3'h0 : samp_cnt_r + 1'b1; // [R6]
        cnt_r <= acq_load;
      end else if (state_r == ST_STORE) begin
        ch_idx_r <= last_ch ? 4'h0 : ch_idx_r + 1'b1; // [R1]
        cnt_r <= acq_load;
      end
    end
  end
  assign adc_start = adc_start_r;
  assign busy = busy_r;

  // channel select held for the core, registered
  logic [3:0] adc_ch_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_ch_r <= 4'h0;
    end else begin
      adc_ch_r <= ch_idx_r;
    end
  end
  assign adc_channel = adc_ch_r;

  // averaging of the samples of one channel
  result_averager u_avg (
    .clk(ref_clk),
    .rst_n(rst_n),
    .clear(state_r == ST_STORE || state_r == ST_IDLE),
    .add(state_r == ST_CONV && adc_done), // [R6]
    .avg_sel(avg_sel),
    .sample(adc_data),
    .mean(mean)
  );

  // one result register per channel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_res
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          res_r[gi] <= '0;
        end else if (state_r == ST_STORE && slot == 4'(gi)) begin
          res_r[gi] <= mean; // [R3] [R13]
        end
      end
    end
  endgenerate

  // own alert is sticky for a sequence; a new start clears it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_own_r <= 1'b0;
      alert_out_r <= 1'b0;
    end else begin
      if (state_r == ST_STORE && alert_en && out_of_range) begin
        alert_own_r <= 1'b1; // [R9]
      end else if (state_r == ST_IDLE && start_req) begin
        alert_own_r <= 1'b0;
      end
      alert_out_r <= alert_own_r | alert_in_s; // [R9]
    end
  end
  assign alert_out = alert_out_r;

endmodule

// ---- dv/cell_monitor_checker.sv ----
// port assertions of the cell monitor conversion control
`timescale 1ns/1ps
module cell_monitor_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // host link and chain relay
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic chain_cs_n_up,
  input wire logic chain_sclk_up,
  input wire logic chain_sdo_up,
  input wire logic chain_conversion_start_pin_n_up,
  // conversion
  input wire logic conversion_start_pin_n,
  input wire logic adc_start,
  input wire logic [3:0] adc_channel,
  input wire logic busy
);
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] up_r;
  logic [9:0] gap_r;
  // cycles since reset release, and since busy rose or the last start pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_r <= 3'h0;
      gap_r <= 10'h000;
    end else begin
      if (up_r != 3'h7) up_r <= up_r + 3'h1;
      if (adc_start || !busy) gap_r <= 10'h000;
      else if (gap_r != 10'h3FF) gap_r <= gap_r + 10'h001;
    end
  end
  property p_acq_min;
    adc_start |-> busy && gap_r >= 10'h062;
  endproperty
  a_acq_min: assert property (p_acq_min) else $error("channel start too early");
  property p_pin_start;
    $fell(conversion_start_pin_n) && !busy && up_r > 3'h3 |-> ##[1:6] busy;
  endproperty
  a_pin_start: assert property (p_pin_start) else $error("start pin ignored");
  property p_ch_step;
    busy && $past(busy) && $changed(adc_channel) |-> adc_channel == $past(adc_channel) + 4'h1;
  endproperty
  a_ch_step: assert property (p_ch_step) else $error("channel order broken");
  property p_last_ch;
    $fell(busy) |-> $past(adc_channel) == 4'hB;
  endproperty
  a_last_ch: assert property (p_last_ch) else $error("sequence ended early");
  property p_ch_range;
    busy |-> adc_channel <= 4'hB;
  endproperty
  a_ch_range: assert property (p_ch_range) else $error("channel out of range");
  property p_sdo_idle;
    spi_cs_n && $past(spi_cs_n) |-> !spi_sdo;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("serial out active while deselected");
  property p_sdi_up;
    up_r > 3'h3 |-> chain_sdo_up == $past(spi_sdi, 3);
  endproperty
  a_sdi_up: assert property (p_sdi_up) else $error("data relay up wrong");
  property p_cs_up;
    up_r > 3'h3 |-> chain_cs_n_up == $past(spi_cs_n, 3);
  endproperty
  a_cs_up: assert property (p_cs_up) else $error("select relay up wrong");
  property p_sclk_up;
    up_r > 3'h3 |-> chain_sclk_up == $past(spi_sclk, 3);
  endproperty
  a_sclk_up: assert property (p_sclk_up) else $error("clock relay up wrong");
  property p_conversion_start_pin_up;
    up_r > 3'h3 |-> chain_conversion_start_pin_n_up == $past(conversion_start_pin_n, 3);
  endproperty
  a_conversion_start_pin_up: assert property (p_conversion_start_pin_up) else $error("start relay up wrong");
  // main scenarios reached
  c_seq_done: cover property ($fell(busy));
  c_conv: cover property (adc_start);
  c_frame: cover property ($rose(chain_cs_n_up));
endmodule
bind cell_monitor_conversion_control cell_monitor_checker u_cell_monitor_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
  .spi_sdo(spi_sdo), .chain_cs_n_up(chain_cs_n_up), .chain_sclk_up(chain_sclk_up),
  .chain_sdo_up(chain_sdo_up), .chain_conversion_start_pin_n_up(chain_conversion_start_pin_n_up),
  .conversion_start_pin_n(conversion_start_pin_n), .adc_start(adc_start), .adc_channel(adc_channel),
  .busy(busy)
);

// ---- dv/adc_core_model.sv ----
// behavioural converter core answering start pulses with channel-coded samples
`timescale 1ns/1ps
module adc_core_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // converter handshake
  input wire logic adc_start,
  input wire logic [3:0] adc_channel,
  output logic adc_done,
  output logic [cell_monitor_pkg::RES_W-1:0] adc_data
);
  import cell_monitor_pkg::*;
  int wait_cnt;
  int idx;
  logic [3:0] last_ch;
  // sample k of channel p reads 0x100+0x40*p+3*k; odd channels answer slowly
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 0;
      idx <= 0;
      last_ch <= 4'hF;
      adc_done <= 1'b0;
      adc_data <= 12'h000;
    end else begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data; // stale data never looks valid
      if (adc_start) begin
        idx <= (adc_channel == last_ch) ? idx + 1 : 0;
        last_ch <= adc_channel;
        wait_cnt <= adc_channel[0] ? 20 : 2;
      end else if (wait_cnt != 0) begin
        wait_cnt <= wait_cnt - 1;
        if (wait_cnt == 1) begin
          adc_done <= 1'b1;
          adc_data <= 12'h100 + 12'h040 * last_ch + 12'(3 * idx);
        end
      end
    end
  end
endmodule

// ---- dv/cell_monitor_conversion_control_tb.sv ----
// self-checking bench of the cell monitor conversion control
`timescale 1ns/1ps
module cell_monitor_conversion_control_tb;
  import cell_monitor_pkg::*;
  localparam logic [2:0] DEV = 3'h2;
  logic ref_clk, rst_n, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, chain_sclk_up, chain_cs_n_up;
  logic chain_sdo_up, chain_conversion_start_pin_n_up, chain_sdi_down, chain_alert_in, conversion_start_pin_n;
  logic adc_start, adc_done, alert_out, busy;
  logic [3:0] adc_channel;
  logic [RES_W-1:0] adc_data;
  logic [NUM_CELLS-1:0] cell_balance_output;
  logic [23:0] down_word;
  logic [22:0] rep;
  logic [1:0] acq;
  int n_fail, cmp_count, n_start, n, c;
  cell_monitor_conversion_control u_cell_monitor_conversion_control (
    .ref_clk(ref_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .chain_sclk_up(chain_sclk_up), .chain_cs_n_up(chain_cs_n_up),
    .chain_sdo_up(chain_sdo_up), .chain_conversion_start_pin_n_up(chain_conversion_start_pin_n_up), .chain_sdi_down(chain_sdi_down),
    .chain_alert_in(chain_alert_in), .conversion_start_pin_n(conversion_start_pin_n),
    .device_addr(DEV), .adc_start(adc_start), .adc_channel(adc_channel), .adc_done(adc_done),
    .adc_data(adc_data), .alert_out(alert_out), .busy(busy), .cell_balance_output(cell_balance_output)
  );
  adc_core_model u_adc_core_model (
    .ref_clk(ref_clk), .rst_n(rst_n), .adc_start(adc_start), .adc_channel(adc_channel),
    .adc_done(adc_done), .adc_data(adc_data)
  );
  // system clock and count of channel start pulses
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (adc_start === 1'b1) n_start++;
  task automatic complete_run();
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one 24-bit frame; 30 ns serial clock, still outside frames
  task automatic spi_frame(input logic [23:0] word, output logic [22:0] reply);
    @(posedge ref_clk);
    #1 spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = word[i];
      chain_sdi_down = down_word[i];
      #15 spi_sclk = 1'b1;
      if (i < 23) reply[i] = spi_sdo;
      #15 spi_sclk = 1'b0;
    end
    #15 spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
    chain_sdi_down = ~chain_sdi_down;
    repeat (20) @(posedge ref_clk);
  endtask
  task automatic chk_reg(input logic [3:0] r, input logic [15:0] exp);
    spi_frame({1'b0, DEV, r, 16'h0000}, rep);
    spi_frame({1'b0, DEV, REG_CTRL, 16'h0000}, rep);
    check(rep, {DEV, r, exp});
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge ref_clk);
    // let the registered status outputs settle after busy drops
    repeat (2) @(posedge ref_clk);
    #1 check(busy, 1'b0);
  endtask
  function automatic logic [15:0] exp_res(input int p, input int a);
    int s;
    s = 0;
    for (int k = 0; k < (1 << a); k++) s += 256 + 64 * p + 3 * k;
    return 16'(s >> a);
  endfunction
  // cut a hung run short
  initial begin
    repeat (80000) @(posedge ref_clk);
    n_fail++;
    complete_run();
  end
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
    chain_sdi_down = 1'b0;
    chain_alert_in = 1'b0;
    conversion_start_pin_n = 1'b1;
    down_word = 24'h00_0000;
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    // power-up defaults
    check(cell_balance_output, 6'h00);
    check(alert_out, 1'b0);
    chk_reg(REG_CTRL, 16'h0000);
    chk_reg(REG_UPPER, 16'h0FFF);
    chk_reg(REG_LOWER, 16'h0000);
    // balance drive; foreign address and result writes are refused
    spi_frame({1'b1, DEV, REG_BAL, 16'h002D}, rep);
    check(cell_balance_output, 6'h2D);
    spi_frame({1'b1, 3'h5, REG_BAL, 16'h0012}, rep);
    spi_frame({1'b1, DEV, REG_CELL0, 16'h0ABC}, rep);
    chk_reg(REG_BAL, 16'h002D);
    chk_reg(REG_CELL0, 16'h0000);
    // data from above passes down while another device is addressed
    spi_frame({1'b0, 3'h5, REG_CELL0, 16'h0000}, rep);
    down_word = 24'hA5_C396;
    spi_frame(24'h00_0000, rep);
    check(rep, down_word[23:1]);
    #1 chain_alert_in = 1'b1;
    repeat (5) @(posedge ref_clk);
    check(alert_out, 1'b1);
    #1 chain_alert_in = 1'b0;
    // pin-started sequences for every averaging setting
    for (int a = 0; a < 4; a++) begin
      acq = 2'(3 - a);
      spi_frame({1'b1, DEV, REG_CTRL, 16'(a * 4 + acq)}, rep);
      n = n_start;
      c = 0;
      @(posedge ref_clk) #1 conversion_start_pin_n = 1'b0;
      while (adc_start !== 1'b1 && c < 2000) begin
        @(posedge ref_clk);
        #1 c++;
        if (c == 3) conversion_start_pin_n = 1'b1;
      end
      check(c >= (100 << acq) && c <= (100 << acq) + 8, 1'b1);
      wait_idle();
      check(n_start - n, 12 << a);
      for (int r = 0; r < 12; r++) chk_reg(4'(r), exp_res(r < 6 ? 5 - r : r, a));
    end
    // select-rise start with a low upper threshold raises the alert
    spi_frame({1'b1, DEV, REG_UPPER, 16'h0050}, rep);
    spi_frame({1'b1, DEV, REG_CTRL, 16'h0030}, rep);
    wait_idle();
    spi_frame({1'b0, DEV, REG_CTRL, 16'h0000}, rep);
    check(busy, 1'b1);
    wait_idle();
    check(alert_out, 1'b1);
    spi_frame({1'b1, DEV, REG_CTRL, 16'h0000}, rep);
    wait_idle();
    chk_reg(REG_CTRL, 16'h0400);
    // second reset while the sequencer is idle
    @(posedge ref_clk) #1 rst_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    check(cell_balance_output, 6'h00);
    check(alert_out, 1'b0);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    chk_reg(REG_UPPER, 16'h0FFF);
    complete_run();
  end
endmodule
